// >>> core/tbk_pkg.sv
// tbk_pkg: shared constants, bus carriers and the state record of the timer bank
package tbk_pkg;

  localparam int NTMR = 8;

  // register word indices; byte address is index times four
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_TEN = 6'h11;
  localparam logic [5:0] IDX_TFLAG = 6'h12;
  localparam logic [5:0] IDX_TMASK = 6'h13;
  localparam logic [5:0] IDX_EFLAG = 6'h14;
  localparam logic [5:0] IDX_EMASK = 6'h15;
  localparam logic [5:0] IDX_SFLAG = 6'h16;
  localparam logic [5:0] IDX_SMASK = 6'h17;
  localparam logic [5:0] IDX_STAT = 6'h18;
  localparam logic [5:0] IDX_BCTL = 6'h19;

  // field positions
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_BAUD_BIT = 1;
  localparam int BCTL_RS_BIT = 0;
  localparam int BCTL_RUN_BIT = 1;
  localparam int LEVEL_FLAG_BIT = 6;
  localparam logic [7:0] EFLAG_USED = 8'h7F;

  // timing counts
  localparam logic [1:0] WD_CNT_LOAD = 2'h2;
  localparam logic [3:0] PRE_FALL = 4'hF;
  localparam logic [3:0] PRE_RISE = 4'h7;
  localparam logic [3:0] BAUD_WRAP = 4'hF;

  // vector groups, ordered by register address
  localparam logic [1:0] GRP_TIMER = 2'h0;
  localparam logic [1:0] GRP_EDGE = 2'h1;
  localparam logic [1:0] GRP_SERIAL = 2'h2;

  typedef enum {SRC_FAST, SRC_DIV16, SRC_MAIN, SRC_EXT} tbk_src_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } tbk_ahb_req_type;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } tbk_ahb_rsp_type;

  typedef struct packed {
    logic [7:0][7:0] lo_cnt;
    logic [7:0][7:0] hi_cnt;
    logic [7:0][7:0] lo_lat;
    logic [7:0][7:0] hi_lat;
    logic [7:0] t_en;
    logic [7:0] t_flag;
    logic [7:0] t_mask;
    logic [7:0] e_flag;
    logic [7:0] e_mask;
    logic [7:0] s_flag;
    logic [7:0] s_mask;
    logic src_sel;
    logic baud_sel;
    logic rs_ctrl;
    logic run_sync;
    logic [2:0] fast_clock_in_s;
    logic [2:0] ext_s;
    logic [2:0][5:0] edge_s;
    logic [1:0] irq_s;
    logic [1:0] rpin_s;
    logic ph;
    logic [3:0] pre16;
    logic [3:0] baud_div;
    logic [1:0] wd_cnt;
    logic rst_oe;
    logic rst_o;
    logic wr_pend;
    logic rd_pend;
    logic addr_hit;
    logic [5:0] addr_idx;
    tbk_ahb_rsp_type rsp;
    logic timer_irq;
    logic irq_req;
    logic [4:0] vec;
    logic ser_tick;
  } tbk_state_type;

  localparam tbk_state_type ST_RST = '{rst_o: 1'b1, irq_s: 2'h3, rpin_s: 2'h3,
                                       rsp: '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000},
                                       default: '0};

  // highest set bit wins; returns {valid, index}
  function automatic logic [3:0] prio_pick(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : prio_pick

  function automatic tbk_src_type timer_src(input int n, input logic sel);
    tbk_src_type s;
    s = SRC_MAIN;
    if (n >= 5 || n == 3) begin
      s = SRC_FAST;
    end else if (n == 4) begin
      s = sel ? SRC_EXT : SRC_FAST;
    end else if (n == 2) begin
      s = SRC_DIV16;
    end
    return s;
  endfunction : timer_src

endpackage : tbk_pkg

// >>> core/tbk_timer_bank.sv
// tbk_timer_bank: eight reloading timers, watchdog, interrupt flags and AHB-Lite register slave

// How it works
// R1: each falling timer-clock edge decrements the low counter by one
// R2: writing a low counter address stores into the low latch only
// R3: reading a counter address returns the live counter, not the latch
// R4: a falling edge with low counter at zero also decrements the high counter
// R5: rising edge with high counter zero sets the flag; enabled flag requests interrupt
// R6: that timeout reloads both counters from their latches
// R7: timer 0 timeout drives the reset pin low for 2 main-clock cycles
// R8: writing a high counter address loads the high latch, then both counters
// R9: timer 0 stays off after reset until its enable bit first rises
// R10: each rise of timer 0 enable reloads it; a fall changes nothing
// R11: timers 7..0 serve pulse width, tones, baud, prescale, time of day, watchdog
// R12: select bit zero: 7-3 fast, 2 fast/16, 1-0 main; one: timer 4 external
// R13: edge sources set their flag only on the chosen transition, unsynced to processor
// R14: level request sets its flag and holds it set while the pin stays low
// R15: writing one clears a flag once, zero does nothing; software must clear
// R16: among enabled flags, highest register address then highest bit picks the vector
// R17: enable bit one lets same flag bit interrupt; enables are read/write
// R18: enabled interrupt drives run/sync high when it was low and control bit zero
// R19: software sets up timers 3 and 4 before enabling the serial ports
// R20: baud reload equals fast clock over sixteen times bit rate, minus one
// R21: serial bit timing runs at one sixteenth of the selected baud timer
// R22: each timer has 8-bit low, high counters and latches; bit n is timer n
// R23: reset clears flags and enables; timer interrupt is OR of enabled flags
module tbk_timer_bank #(
  parameter logic [5:0] EDGE_POL = 6'h3F
) (
  input wire logic mclk, // main clock
  input wire logic rstn, // async reset, active low
  input wire tbk_pkg::tbk_ahb_req_type ahb_req, // AHB-Lite address phase
  input wire logic [31:0] hwdata, // AHB-Lite write data
  output tbk_pkg::tbk_ahb_rsp_type ahb_rsp, // AHB-Lite response
  input wire logic fast_clock_in, // fast timer clock pin
  input wire logic external_timer_input_pin, // timer 4 external clock pin
  input wire logic [5:0] edge_irq_pin, // edge interrupt pins
  input wire logic irq_level_pin_n, // level interrupt pin, low active
  input wire logic [7:0] serial_event, // serial interrupt pulses, same clock
  input wire logic chip_reset_pin_n_i, // reset pin level
  output logic chip_reset_pin_n_o, // reset pin drive value
  output logic chip_reset_pin_n_oe, // reset pin drive enable
  output logic run_sync_out, // run/sync output
  output logic timer_irq, // timer interrupt request
  output logic irq_req, // any enabled interrupt
  output logic [4:0] irq_vector, // {group, bit} of winning flag
  output logic serial_bit_tick // serial rate pulse
);

  tbk_pkg::tbk_state_type st_q;
  tbk_pkg::tbk_state_type st_d;
  logic fast_fall;
  logic fast_rise;
  logic ext_fall;
  logic ext_rise;
  logic div_fall;
  logic div_rise;
  logic [7:0] fall;
  logic [7:0] rise;
  logic [7:0] tmo;
  logic wr_go;
  logic [7:0] wd;
  logic [2:0] wn;
  logic [7:0] tclr;
  logic [7:0] eclr;
  logic [7:0] sclr;
  logic [7:0] eset;
  logic [3:0] tp;
  logic [3:0] ep;
  logic [3:0] sp;
  logic baud_src;
  logic [31:0] rd_val;
  logic addr_ok;

  always_comb begin
    st_d = st_q;
    fall = 8'h00;
    rise = 8'h00;
    tmo = 8'h00;
    tclr = 8'h00;
    eclr = 8'h00;
    sclr = 8'h00;
    eset = 8'h00;
    wd = hwdata[7:0];
    wn = st_q.addr_idx[3:1];
    wr_go = st_q.wr_pend && st_q.addr_hit;
    rd_val = 32'h0000_0000;

    // pin synchronisers: stage 0 feeds stage 1 only, stage 2 is the edge delay
    st_d.fast_clock_in_s = {st_q.fast_clock_in_s[1:0], fast_clock_in};
    st_d.ext_s = {st_q.ext_s[1:0], external_timer_input_pin};
    st_d.edge_s = {st_q.edge_s[1:0], edge_irq_pin};
    st_d.irq_s = {st_q.irq_s[0], irq_level_pin_n};
    st_d.rpin_s = {st_q.rpin_s[0], chip_reset_pin_n_i};
    fast_fall = st_q.fast_clock_in_s[2] && !st_q.fast_clock_in_s[1];
    fast_rise = !st_q.fast_clock_in_s[2] && st_q.fast_clock_in_s[1];
    ext_fall = st_q.ext_s[2] && !st_q.ext_s[1];
    ext_rise = !st_q.ext_s[2] && st_q.ext_s[1];

    // fast/16 prescaler and main-clock phase
    st_d.ph = !st_q.ph;
    if (fast_fall) begin
      st_d.pre16 = st_q.pre16 + 4'h1;
    end
    div_fall = fast_fall && st_q.pre16 == tbk_pkg::PRE_FALL;
    div_rise = fast_fall && st_q.pre16 == tbk_pkg::PRE_RISE;

    // per-timer clock source, then count and reload
    for (int n = 0; n < tbk_pkg::NTMR; n++) begin
      case (tbk_pkg::timer_src(n, st_q.src_sel)) // see R11 see R12
        tbk_pkg::SRC_FAST: begin
          fall[n] = fast_fall;
          rise[n] = fast_rise;
        end
        tbk_pkg::SRC_DIV16: begin
          fall[n] = div_fall;
          rise[n] = div_rise;
        end
        tbk_pkg::SRC_EXT: begin
          fall[n] = ext_fall;
          rise[n] = ext_rise;
        end
        default: begin
          fall[n] = st_q.ph;
          rise[n] = !st_q.ph;
        end
      endcase
      if (st_q.t_en[n] && fall[n]) begin // see R9
        st_d.lo_cnt[n] = st_q.lo_cnt[n] - 8'h01; // see R1
        if (st_q.lo_cnt[n] == 8'h00) begin
          st_d.hi_cnt[n] = st_q.hi_cnt[n] - 8'h01; // see R4
        end
      end
      if (st_q.t_en[n] && rise[n] && st_q.hi_cnt[n] == 8'h00) begin
        tmo[n] = 1'b1; // see R5
        st_d.lo_cnt[n] = st_q.lo_lat[n]; // see R6
        st_d.hi_cnt[n] = st_q.hi_lat[n]; // see R6
      end
    end

    // AHB-Lite: capture address phase, apply writes in data phase
    addr_ok = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    st_d.wr_pend = addr_ok && ahb_req.hwrite;
    st_d.rd_pend = addr_ok && !ahb_req.hwrite;
    st_d.addr_hit = ahb_req.haddr[31:8] == 24'h00_0000 && ahb_req.haddr[7:2] <= tbk_pkg::IDX_BCTL;
    st_d.addr_idx = ahb_req.haddr[7:2];
    st_d.rsp.hresp = 1'b0;
    st_d.rsp.hreadyout = !(addr_ok && !ahb_req.hwrite);

    if (wr_go) begin
      if (st_q.addr_idx < tbk_pkg::IDX_CTRL) begin
        if (!st_q.addr_idx[0]) begin
          st_d.lo_lat[wn] = wd; // see R2
        end else begin
          st_d.hi_lat[wn] = wd; // see R8
          st_d.hi_cnt[wn] = wd; // see R8
          st_d.lo_cnt[wn] = st_q.lo_lat[wn]; // see R8
        end
      end else begin
        case (st_q.addr_idx)
          tbk_pkg::IDX_CTRL: begin
            st_d.src_sel = wd[tbk_pkg::CTRL_SRC_BIT];
            st_d.baud_sel = wd[tbk_pkg::CTRL_BAUD_BIT];
          end
          tbk_pkg::IDX_TEN: begin
            st_d.t_en = wd;
            if (wd[0] && !st_q.t_en[0]) begin
              st_d.lo_cnt[0] = st_q.lo_lat[0]; // see R10
              st_d.hi_cnt[0] = st_q.hi_lat[0]; // see R10
            end
          end
          tbk_pkg::IDX_TFLAG: tclr = wd; // see R15
          tbk_pkg::IDX_TMASK: st_d.t_mask = wd; // see R17
          tbk_pkg::IDX_EFLAG: eclr = wd; // see R15
          tbk_pkg::IDX_EMASK: st_d.e_mask = wd; // see R17
          tbk_pkg::IDX_SFLAG: sclr = wd; // see R15
          tbk_pkg::IDX_SMASK: st_d.s_mask = wd; // see R17
          tbk_pkg::IDX_BCTL: begin
            st_d.rs_ctrl = wd[tbk_pkg::BCTL_RS_BIT];
            st_d.run_sync = wd[tbk_pkg::BCTL_RUN_BIT];
          end
          default: begin
          end
        endcase
      end
    end

    // edge sources fire on chosen polarity; level source held while low
    for (int i = 0; i < 6; i++) begin
      eset[i] = EDGE_POL[i] ? (st_q.edge_s[1][i] && !st_q.edge_s[2][i]) // see R13
                            : (!st_q.edge_s[1][i] && st_q.edge_s[2][i]);
    end
    eset[tbk_pkg::LEVEL_FLAG_BIT] = !st_q.irq_s[1]; // see R14

    // clear then set: an event in the clearing cycle survives
    st_d.t_flag = (st_q.t_flag & ~tclr) | tmo; // see R15 see R5
    st_d.e_flag = ((st_q.e_flag & ~eclr) | eset) & tbk_pkg::EFLAG_USED; // see R15
    st_d.s_flag = (st_q.s_flag & ~sclr) | serial_event; // see R15

    // vector choice: serial group above edge above timer
    tp = tbk_pkg::prio_pick(st_d.t_flag & st_d.t_mask); // see R16
    ep = tbk_pkg::prio_pick(st_d.e_flag & st_d.e_mask); // see R16
    sp = tbk_pkg::prio_pick(st_d.s_flag & st_d.s_mask); // see R16
    st_d.timer_irq = |(st_d.t_flag & st_d.t_mask); // see R23
    st_d.irq_req = tp[3] || ep[3] || sp[3]; // see R17
    if (sp[3]) begin
      st_d.vec = {tbk_pkg::GRP_SERIAL, sp[2:0]}; // see R16
    end else if (ep[3]) begin
      st_d.vec = {tbk_pkg::GRP_EDGE, ep[2:0]};
    end else begin
      st_d.vec = {tbk_pkg::GRP_TIMER, tp[2:0]};
    end
    if (st_d.irq_req && !st_d.rs_ctrl) begin
      st_d.run_sync = 1'b1; // see R18
    end

    // watchdog restart pulse, not retriggered while active
    if (tmo[0] && st_q.wd_cnt == 2'h0) begin
      st_d.wd_cnt = tbk_pkg::WD_CNT_LOAD; // see R7
    end else if (st_q.wd_cnt != 2'h0) begin
      st_d.wd_cnt = st_q.wd_cnt - 2'h1;
    end
    st_d.rst_oe = st_d.wd_cnt != 2'h0; // see R7
    st_d.rst_o = !st_d.rst_oe;

    // serial rate: one pulse per sixteen timeouts of the chosen baud timer
    baud_src = st_q.baud_sel ? tmo[4] : tmo[3];
    st_d.ser_tick = 1'b0;
    if (baud_src) begin
      st_d.baud_div = st_q.baud_div + 4'h1;
      st_d.ser_tick = st_q.baud_div == tbk_pkg::BAUD_WRAP; // see R21
    end

    // read data, one wait state so a just-written value is seen
    if (st_q.addr_hit) begin
      if (st_q.addr_idx < tbk_pkg::IDX_CTRL) begin
        rd_val[7:0] = st_q.addr_idx[0] ? st_q.hi_cnt[wn] : st_q.lo_cnt[wn]; // see R3
      end else begin
        case (st_q.addr_idx)
          tbk_pkg::IDX_CTRL: rd_val[1:0] = {st_q.baud_sel, st_q.src_sel};
          tbk_pkg::IDX_TEN: rd_val[7:0] = st_q.t_en;
          tbk_pkg::IDX_TFLAG: rd_val[7:0] = st_q.t_flag;
          tbk_pkg::IDX_TMASK: rd_val[7:0] = st_q.t_mask; // see R17
          tbk_pkg::IDX_EFLAG: rd_val[7:0] = st_q.e_flag;
          tbk_pkg::IDX_EMASK: rd_val[7:0] = st_q.e_mask;
          tbk_pkg::IDX_SFLAG: rd_val[7:0] = st_q.s_flag;
          tbk_pkg::IDX_SMASK: rd_val[7:0] = st_q.s_mask;
          tbk_pkg::IDX_STAT: rd_val[7:0] = {st_q.rpin_s[1], st_q.run_sync, st_q.irq_req, st_q.vec};
          tbk_pkg::IDX_BCTL: rd_val[1:0] = {st_q.run_sync, st_q.rs_ctrl};
          default: rd_val = 32'h0000_0000;
        endcase
      end
    end
    if (st_q.rd_pend) begin
      st_d.rsp.hrdata = rd_val;
      st_d.rsp.hreadyout = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= tbk_pkg::ST_RST; // see R23 see R22
    end else begin
      st_q <= st_d;
    end
  end

  assign ahb_rsp = st_q.rsp;
  assign chip_reset_pin_n_o = st_q.rst_o;
  assign chip_reset_pin_n_oe = st_q.rst_oe;
  assign run_sync_out = st_q.run_sync;
  assign timer_irq = st_q.timer_irq;
  assign irq_req = st_q.irq_req;
  assign irq_vector = st_q.vec;
  assign serial_bit_tick = st_q.ser_tick;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  wd_pulse_len_a: assert property ($rose(chip_reset_pin_n_oe) |-> chip_reset_pin_n_oe [*2] ##1 !chip_reset_pin_n_oe) // see R7
    else $error("watchdog reset pulse not two cycles");

  wd_cause_a: assert property (tmo[0] && st_q.wd_cnt == 2'h0 |=> chip_reset_pin_n_oe && !chip_reset_pin_n_o) // see R7
    else $error("watchdog timeout did not drive reset pin");

  flag_set_a: assert property (|tmo |=> (st_q.t_flag & $past(tmo)) == $past(tmo)) // see R5
    else $error("timeout did not set its flag");

  timeout_reload_a: assert property (tmo[1] && !wr_go |=> // see R6
    st_q.lo_cnt[1] == $past(st_q.lo_lat[1]) && st_q.hi_cnt[1] == $past(st_q.hi_lat[1]))
    else $error("timeout did not reload counters");

  lo_latch_a: assert property (wr_go && st_q.addr_idx < tbk_pkg::IDX_CTRL && !st_q.addr_idx[0] |=> // see R2
    st_q.lo_lat[$past(st_q.addr_idx[3:1])] == $past(hwdata[7:0]))
    else $error("low write missed the latch");

  hi_load_a: assert property (wr_go && st_q.addr_idx < tbk_pkg::IDX_CTRL && st_q.addr_idx[0] |=> // see R8
    st_q.hi_cnt[$past(st_q.addr_idx[3:1])] == $past(hwdata[7:0]) &&
    st_q.lo_cnt[$past(st_q.addr_idx[3:1])] == $past(st_q.lo_lat[st_q.addr_idx[3:1]]))
    else $error("high write did not load counters");

  flag_w1c_a: assert property (wr_go && st_q.addr_idx == tbk_pkg::IDX_TFLAG && tmo == 8'h00 |=> // see R15
    (st_q.t_flag & $past(hwdata[7:0])) == 8'h00)
    else $error("write one did not clear flag");

  wd_enable_a: assert property (wr_go && st_q.addr_idx == tbk_pkg::IDX_TEN && hwdata[0] && !st_q.t_en[0] |=> // see R10
    st_q.lo_cnt[0] == $past(st_q.lo_lat[0]) && st_q.hi_cnt[0] == $past(st_q.hi_lat[0]))
    else $error("timer 0 enable rise did not reload");

  live_read_a: assert property (st_q.rd_pend && st_q.addr_hit && st_q.addr_idx == 6'h00 |=> // see R3
    ahb_rsp.hreadyout && ahb_rsp.hrdata[7:0] == $past(st_q.lo_cnt[0]))
    else $error("counter read not live");

  level_hold_a: assert property (!st_q.irq_s[1] |=> st_q.e_flag[tbk_pkg::LEVEL_FLAG_BIT]) // see R14
    else $error("level flag not held");

  prio_pick_a: assert property (irq_req && (|(st_q.s_flag & st_q.s_mask)) |-> irq_vector[4:3] == tbk_pkg::GRP_SERIAL) // see R16
    else $error("serial group not preferred");

  run_sync_a: assert property (irq_req && !st_q.rs_ctrl |-> run_sync_out) // see R18
    else $error("run/sync not raised by interrupt");

  timer_or_a: assert property (timer_irq == |(st_q.t_flag & st_q.t_mask)) // see R23
    else $error("timer interrupt not OR of enabled flags");

  count_dec_a: assert property (st_q.t_en[3] && fall[3] && !wr_go |=> // see R1
    st_q.lo_cnt[3] == $past(st_q.lo_cnt[3]) - 8'h01)
    else $error("low counter did not step down");

  hi_borrow_a: assert property (st_q.t_en[5] && fall[5] && st_q.lo_cnt[5] == 8'h00 && !wr_go |=> // see R4
    st_q.hi_cnt[5] == $past(st_q.hi_cnt[5]) - 8'h01)
    else $error("high counter did not borrow");

  ext_count_a: assert property (st_q.src_sel && st_q.t_en[4] && ext_fall && !wr_go |=> // see R12
    st_q.lo_cnt[4] == $past(st_q.lo_cnt[4]) - 8'h01)
    else $error("timer 4 missed external edge");

  ext_only_a: assert property (st_q.src_sel && st_q.t_en[4] && !ext_fall && !ext_rise && !wr_go |=> // see R12
    st_q.lo_cnt[4] == $past(st_q.lo_cnt[4]))
    else $error("timer 4 counted without external edge");

  wd_frozen_a: assert property (!st_q.t_en[0] && !wr_go |=> // see R9
    st_q.lo_cnt[0] == $past(st_q.lo_cnt[0]))
    else $error("timer 0 moved while disabled");

  edge_set_a: assert property (EDGE_POL[3] && st_q.edge_s[1][3] && !st_q.edge_s[2][3] |=> // see R13
    st_q.e_flag[3])
    else $error("edge did not set its flag");

  edge_hold_a: assert property (!st_q.e_flag[3] && st_q.edge_s[1][3] == st_q.edge_s[2][3] |=> // see R13
    !st_q.e_flag[3])
    else $error("edge flag set without a transition");

  irq_or_a: assert property (irq_req == (|(st_q.t_flag & st_q.t_mask) || // see R17
    |(st_q.e_flag & st_q.e_mask) || |(st_q.s_flag & st_q.s_mask)))
    else $error("interrupt request not OR of enabled flags");

  edge_prio_a: assert property (irq_req && !(|(st_q.s_flag & st_q.s_mask)) && |(st_q.e_flag & st_q.e_mask) |-> // see R16
    irq_vector[4:3] == tbk_pkg::GRP_EDGE)
    else $error("edge group not preferred over timers");

  bit_prio_a: assert property (irq_req && irq_vector[4:3] == tbk_pkg::GRP_TIMER |-> // see R16
    ((st_q.t_flag & st_q.t_mask) >> irq_vector[2:0]) == 8'h01)
    else $error("timer vector not highest enabled bit");

  tick_rate_a: assert property (serial_bit_tick |-> // see R21
    $past(st_q.baud_div) == tbk_pkg::BAUD_WRAP && st_q.baud_div == 4'h0)
    else $error("serial tick not on sixteenth timeout");

  rd_wait_a: assert property (st_q.rd_pend |-> // see R3
    !ahb_rsp.hreadyout)
    else $error("read data phase without wait state");

endmodule : tbk_timer_bank

// >>> sim/tbk_ahb_master.sv
// tbk_ahb_master: processor-side AHB-Lite single-transfer master model
module tbk_ahb_master (
  input wire logic mclk, // main clock
  output tbk_pkg::tbk_ahb_req_type ahb_req, // address phase signals
  output logic [31:0] hwdata, // write data
  input wire tbk_pkg::tbk_ahb_rsp_type ahb_rsp // slave response
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel_q = 1'b0;
  logic wr_q = 1'b0;
  logic [1:0] trans_q = 2'h0;
  logic [31:0] addr_q = 32'h0000_0000;
  initial hwdata = 32'h0000_0000;
  // the one slave's hreadyout is the bus hready
  assign ahb_req = '{hsel: sel_q, haddr: addr_q, htrans: trans_q, hwrite: wr_q, hsize: 3'h2,
                     hready: ahb_rsp.hreadyout};

  // address held until hready, then data held until hready again
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    sel_q <= 1'b1;
    wr_q <= wr;
    trans_q <= 2'h2;
    addr_q <= {24'h00_0000, idx, 2'b00};
    do @(posedge mclk); while (ahb_rsp.hreadyout !== 1'b1);
    sel_q <= 1'b0;
    trans_q <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    do @(posedge mclk); while (ahb_rsp.hreadyout !== 1'b1);
    rd = ahb_rsp.hrdata[7:0];
    // released data lines do not keep the last value
    hwdata <= ~{24'h00_0000, wd};
  endtask : xfer
endmodule : tbk_ahb_master

// >>> sim/tbk_timer_bank_bench.sv
// tbk_timer_bank_bench: self-checking bench for the timer bank
module tbk_timer_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  tbk_pkg::tbk_ahb_req_type ahb_req;
  logic [31:0] hwdata;
  tbk_pkg::tbk_ahb_rsp_type ahb_rsp;
  logic fast_clk = 1'b0;
  logic ext_pin = 1'b0;
  logic [5:0] edge_pin = 6'h00;
  logic level_n = 1'b1;
  logic [7:0] ser_ev = 8'h00;
  logic rpin_n_o, rpin_oe, run_sync_out, timer_irq, irq_req, tick;
  logic [4:0] vec;
  wire logic rpin_n = rpin_oe ? rpin_n_o : 1'b1; // pull-up on the reset pin
  int err_count = 0;
  int checked = 0;
  int ticks = 0;

  always #20 mclk = ~mclk;

  // serial rate pulses seen since reset
  always @(posedge mclk) begin
    if (tick === 1'b1) ticks++;
  end

  tbk_ahb_master mst_u (.mclk(mclk), .ahb_req(ahb_req), .hwdata(hwdata), .ahb_rsp(ahb_rsp));
  tbk_timer_bank dut_u (.mclk(mclk), .rstn(rstn), .ahb_req(ahb_req), .hwdata(hwdata), .ahb_rsp(ahb_rsp),
    .fast_clock_in(fast_clk), .external_timer_input_pin(ext_pin), .edge_irq_pin(edge_pin),
    .irq_level_pin_n(level_n), .serial_event(ser_ev), .chip_reset_pin_n_i(rpin_n),
    .chip_reset_pin_n_o(rpin_n_o), .chip_reset_pin_n_oe(rpin_oe), .run_sync_out(run_sync_out),
    .timer_irq(timer_irq), .irq_req(irq_req), .irq_vector(vec), .serial_bit_tick(tick));

  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] nothing;
    mst_u.xfer(1'b1, idx, d, nothing);
  endtask : wr

  task automatic rdc(input string what, input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    mst_u.xfer(1'b0, idx, 8'h00, got);
    chk_reg(what, exp, got);
  endtask : rdc

  // n pulses, each one rise then one fall, of the fast or external timer clock
  task automatic pulse(input bit ext, input int n);
    repeat (n) begin
      if (ext) ext_pin <= 1'b1; else fast_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      if (ext) ext_pin <= 1'b0; else fast_clk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask : pulse

  task automatic t_reset;
    rdc("ten", tbk_pkg::IDX_TEN, 8'h00);
    rdc("tflag", tbk_pkg::IDX_TFLAG, 8'h00);
    rdc("tmask", tbk_pkg::IDX_TMASK, 8'h00);
    rdc("eflag", tbk_pkg::IDX_EFLAG, 8'h00);
    rdc("smask", tbk_pkg::IDX_SMASK, 8'h00);
    rdc("stat", tbk_pkg::IDX_STAT, 8'h80);
    $display("test reset done");
  endtask : t_reset

  task automatic t_latch;
    wr(6'h06, 8'h05);
    wr(6'h07, 8'h07);
    rdc("t3 lo", 6'h06, 8'h05);
    rdc("t3 hi", 6'h07, 8'h07);
    wr(6'h06, 8'h09);
    rdc("t3 lo live", 6'h06, 8'h05);
    $display("test latch done");
  endtask : t_latch

  task automatic t_count;
    wr(tbk_pkg::IDX_CTRL, 8'h01);
    wr(6'h06, 8'h0A);
    wr(6'h07, 8'h01);
    wr(6'h08, 8'h0A);
    wr(6'h09, 8'h01);
    wr(6'h0A, 8'h01);
    wr(6'h0B, 8'h02);
    wr(6'h0C, 8'h01);
    wr(6'h0D, 8'h00);
    wr(tbk_pkg::IDX_TEN, 8'h78);
    pulse(0, 3);
    rdc("t3 lo", 6'h06, 8'h07);
    rdc("t4 lo", 6'h08, 8'h0A);
    rdc("t5 lo", 6'h0A, 8'hFE);
    rdc("t5 hi", 6'h0B, 8'h01);
    rdc("t6 lo", 6'h0C, 8'h00);
    rdc("t6 hi", 6'h0D, 8'h00);
    rdc("tflag", tbk_pkg::IDX_TFLAG, 8'h40);
    pulse(1, 2);
    rdc("t4 lo ext", 6'h08, 8'h08);
    rdc("t3 lo ext", 6'h06, 8'h07);
    wr(tbk_pkg::IDX_TEN, 8'h00);
    wr(tbk_pkg::IDX_TFLAG, 8'hFF);
    rdc("tflag clr", tbk_pkg::IDX_TFLAG, 8'h00);
    $display("test count done");
  endtask : t_count

  task automatic t_irq;
    wr(6'h02, 8'h01);
    wr(6'h03, 8'h00);
    wr(tbk_pkg::IDX_TEN, 8'h02);
    repeat (8) @(posedge mclk);
    wr(tbk_pkg::IDX_TEN, 8'h00);
    rdc("tflag t1", tbk_pkg::IDX_TFLAG, 8'h02);
    chk_pin("timer_irq off", 1'b0, timer_irq);
    wr(tbk_pkg::IDX_TMASK, 8'h02);
    rdc("tmask", tbk_pkg::IDX_TMASK, 8'h02);
    chk_pin("timer_irq", 1'b1, timer_irq);
    chk_reg("vec t1", 8'h01, {3'h0, vec});
    chk_pin("run_sync", 1'b1, run_sync_out);
    edge_pin[3] <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(tbk_pkg::IDX_EMASK, 8'h08);
    repeat (2) @(posedge mclk);
    chk_reg("vec e3", {3'h0, tbk_pkg::GRP_EDGE, 3'h3}, {3'h0, vec});
    wr(tbk_pkg::IDX_EFLAG, 8'h08);
    edge_pin[3] <= 1'b0;
    repeat (6) @(posedge mclk);
    rdc("eflag fall", tbk_pkg::IDX_EFLAG, 8'h00);
    chk_reg("vec back", 8'h01, {3'h0, vec});
    ser_ev[2] <= 1'b1;
    @(posedge mclk);
    ser_ev[2] <= 1'b0;
    wr(tbk_pkg::IDX_SMASK, 8'h04);
    repeat (2) @(posedge mclk);
    chk_reg("vec s2", {3'h0, tbk_pkg::GRP_SERIAL, 3'h2}, {3'h0, vec});
    wr(tbk_pkg::IDX_SFLAG, 8'h04);
    level_n <= 1'b0;
    repeat (6) @(posedge mclk);
    wr(tbk_pkg::IDX_EFLAG, 8'h40);
    rdc("level held", tbk_pkg::IDX_EFLAG, 8'h40);
    level_n <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(tbk_pkg::IDX_EFLAG, 8'h40);
    rdc("level clr", tbk_pkg::IDX_EFLAG, 8'h00);
    wr(tbk_pkg::IDX_TFLAG, 8'h00);
    rdc("write zero", tbk_pkg::IDX_TFLAG, 8'h02);
    wr(tbk_pkg::IDX_TFLAG, 8'h02);
    repeat (3) @(posedge mclk);
    chk_pin("timer_irq clr", 1'b0, timer_irq);
    chk_pin("irq_req clr", 1'b0, irq_req);
    $display("test irq done");
  endtask : t_irq

  task automatic t_baud;
    wr(6'h06, 8'h01);
    wr(6'h07, 8'h00);
    wr(tbk_pkg::IDX_CTRL, 8'h00);
    wr(tbk_pkg::IDX_TEN, 8'h08);
    pulse(0, 32);
    chk_reg("ticks t3", 8'h02, 8'(ticks));
    wr(6'h08, 8'h01);
    wr(6'h09, 8'h00);
    wr(tbk_pkg::IDX_CTRL, 8'h02);
    wr(tbk_pkg::IDX_TEN, 8'h10);
    pulse(0, 16);
    chk_reg("ticks t4", 8'h03, 8'(ticks));
    wr(tbk_pkg::IDX_TEN, 8'h00);
    $display("test baud done");
  endtask : t_baud

  task automatic t_wdog;
    int n;
    n = 0;
    wr(6'h00, 8'h01);
    wr(6'h01, 8'h00);
    rdc("t0 lo", 6'h00, 8'h01);
    repeat (20) begin
      @(posedge mclk);
      if (rpin_oe !== 1'b0) n++;
    end
    chk_reg("wd idle", 8'h00, 8'(n));
    wr(tbk_pkg::IDX_TEN, 8'h01);
    for (int i = 0; i < 50 && rpin_oe !== 1'b1; i++) @(posedge mclk);
    n = 0;
    while (rpin_oe === 1'b1 && n < 9) begin
      chk_pin("wd level", 1'b0, rpin_n);
      @(posedge mclk);
      n++;
    end
    chk_reg("wd width", 8'h02, 8'(n));
    wr(tbk_pkg::IDX_TEN, 8'h00);
    $display("test watchdog done");
  endtask : t_wdog

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_latch;
    t_count;
    t_irq;
    t_baud;
    t_wdog;
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("[FAIL] run time expected under 20000 cycles seen hang");
    end_of_test;
  end
endmodule : tbk_timer_bank_bench
